//--- lkbe_params.svh
// Offsets, port numbers, field positions and reset values of the keyboard emulation registers
`ifndef LKBE_PARAMS_SVH
`define LKBE_PARAMS_SVH

// Operational space byte offsets
`define LKBE_OFS_INPUT     12'h104
`define LKBE_OFS_OUTPUT    12'h108
`define LKBE_OFS_STATUS    12'h10C

// Legacy I/O ports
`define LKBE_PORT_DATA     16'h0060
`define LKBE_PORT_CMD      16'h0064

// Command byte that opens a Gate A20 sequence
`define LKBE_CMD_GATE_A20  8'hD1

// Status field positions
`define LKBE_ST_OUT_FULL   0
`define LKBE_ST_IN_FULL    1
`define LKBE_ST_FLAG       2
`define LKBE_ST_CMD_DATA   3
`define LKBE_ST_INHIBIT    4
`define LKBE_ST_AUX_FULL   5
`define LKBE_ST_TIMEOUT    6
`define LKBE_ST_PARITY     7

// Reset values
`define LKBE_RST_BYTE      8'h00
`define LKBE_RST_WORD      32'h0000_0000

`endif

//--- lkbe_pkg.sv
// Types and shared decode helpers of the keyboard emulation registers
package lkbe_pkg;

	typedef struct packed {
		logic [7:0]  inByte;
		logic [7:0]  outByte;
		logic [7:0]  status;
		logic        gateA20;
		logic [31:0] memRdata;
		logic        memAck;
		logic [7:0]  ioRdata;
		logic        ioAck;
		logic        ioHit;
		logic        kbdIrq;
		logic        mouseIrq;
		logic        emuIrq;
	} lkbe_state_t;

	function automatic logic lkbePortHit(input logic [15:0] addr, input logic [15:0] port);
		lkbePortHit = (addr == port);
	endfunction

endpackage

//--- lkbe_io_decode.sv
// Legacy port decoder: turns an I/O request into port 60h/64h strobes
`timescale 1ns/10ps
`include "lkbe_params.svh"

module lkbe_io_decode
	import lkbe_pkg::*;
(
	// Request
	input  wire logic        ioReq,
	input  wire logic        ioWrite,
	input  wire logic [15:0] ioAddr,
	// Control
	input  wire logic        emulationEnableBit,
	// Strobes
	output logic             wrData,
	output logic             wrCmd,
	output logic             rdData,
	output logic             rdCmd
);

	logic hitData;
	logic hitCmd;
	logic live;

	always_comb begin
		// Ports are only claimed while emulation is on
		live    = ioReq & emulationEnableBit;
		hitData = lkbePortHit(ioAddr, `LKBE_PORT_DATA);
		hitCmd  = lkbePortHit(ioAddr, `LKBE_PORT_CMD);
		wrData  = live & ioWrite & hitData;
		wrCmd   = live & ioWrite & hitCmd;
		rdData  = live & ~ioWrite & hitData;
		rdCmd   = live & ~ioWrite & hitCmd;
	end

endmodule

//--- lkbe_emul_regs.sv
// Legacy keyboard controller emulation registers with port 60h/64h side effects
//
// Functional notes
// - Enabled port 60h/64h writes capture input byte
// - Memory access to input byte: no side effects
// - Input byte in bits 7:0, upper reserved
// - Enabled port 60h read returns output byte
// - Port 60h read clears output-full, unless a same-cycle status write sets it
// - Enabled port 64h read returns status
// - Memory access to status: no side effects
// - Command flag: 60h write clears, 64h sets
// - Port writes set input-full, except Gate A20
// - Emulation interrupt while input-full and enabled
// - Emulation interrupt when output empty, pending set
// - Mouse line: aux-full, output-full, drive enable
// - Aux-full selects which legacy line drives
// - Status bits: parity, timeout, inhibit switch
// - Status bit 2 plain software flag
// - Keyboard line when aux-full clear, else mouse
// - Ports decoded only while emulation enabled
// - D1h to 64h opens Gate A20 sequence
`timescale 1ns/10ps
`include "lkbe_params.svh"

module lkbe_emul_regs
	import lkbe_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,

	// Emulation control bits
	input  wire logic        emulationEnableBit,
	input  wire logic        irqDriveEnable,
	input  wire logic        charPending,

	// Operational register space (memory cycles)
	input  wire logic        memReq,
	input  wire logic        memWrite,
	input  wire logic [11:0] memAddr,
	input  wire logic [31:0] memWdata,
	output logic      [31:0] memRdata,
	output logic             memAck,

	// Legacy I/O cycles
	input  wire logic        ioReq,
	input  wire logic        ioWrite,
	input  wire logic [15:0] ioAddr,
	input  wire logic [7:0]  ioWdata,
	output logic      [7:0]  ioRdata,
	output logic             ioAck,
	output logic             ioHit,

	// Interrupts and sequence state
	output logic             keyboardInterruptLine,
	output logic             mouseInterruptLine,
	output logic             emulationInterrupt,
	output logic             gateA20SequenceActive
);

	lkbe_state_t state;
	lkbe_state_t next_state;

	logic wrData;
	logic wrCmd;
	logic rdData;
	logic rdCmd;

	lkbe_io_decode uDecode (
		.ioReq              (ioReq),
		.ioWrite            (ioWrite),
		.ioAddr             (ioAddr),
		.emulationEnableBit (emulationEnableBit),
		.wrData             (wrData),
		.wrCmd              (wrCmd),
		.rdData             (rdData),
		.rdCmd              (rdCmd)
	);

	function automatic logic [31:0] widen(input logic [7:0] b);
		widen = {24'h00_0000, b};
	endfunction

	always_comb begin
		logic memStatusWr;
		logic a20Part;
		logic outFullSetByMem;
		memStatusWr     = 1'b0;
		a20Part         = 1'b0;
		outFullSetByMem = 1'b0;
		next_state        = state;
		next_state.memAck = 1'b0;
		next_state.ioAck  = 1'b0;
		next_state.ioHit  = 1'b0;

		// Memory cycles move values only, no flag or interrupt effects
		if (memReq) begin
			next_state.memAck   = 1'b1;
			next_state.memRdata = `LKBE_RST_WORD;
			case (memAddr)
				`LKBE_OFS_INPUT: begin
					next_state.memRdata = widen(state.inByte);
					if (memWrite) begin
						next_state.inByte = memWdata[7:0];
					end
				end
				`LKBE_OFS_OUTPUT: begin
					next_state.memRdata = widen(state.outByte);
					if (memWrite) begin
						next_state.outByte = memWdata[7:0];
					end
				end
				`LKBE_OFS_STATUS: begin
					next_state.memRdata = widen(state.status);
					if (memWrite) begin
						// Parity, timeout, inhibit and flag are plain storage
						next_state.status = memWdata[7:0];
						memStatusWr       = 1'b1;
					end
				end
				default: begin
					next_state.memRdata = `LKBE_RST_WORD;
				end
			endcase
		end
		outFullSetByMem = memStatusWr & memWdata[`LKBE_ST_OUT_FULL];

		// Legacy port cycles; hardware-set flags win over a same-cycle memory write
		if (ioReq) begin
			next_state.ioAck   = 1'b1;
			next_state.ioHit   = wrData | wrCmd | rdData | rdCmd;
			next_state.ioRdata = `LKBE_RST_BYTE;
		end

		if (rdData) begin
			next_state.ioRdata = state.outByte;
			// Fresh output from emulation software in the same cycle keeps the flag
			if (!outFullSetByMem) begin
				next_state.status[`LKBE_ST_OUT_FULL] = 1'b0;
			end
		end

		if (rdCmd) begin
			next_state.ioRdata = state.status;
		end

		if (wrData | wrCmd) begin
			next_state.inByte = ioWdata;
		end

		if (wrData) begin
			next_state.status[`LKBE_ST_CMD_DATA] = 1'b0;
			// Data byte following D1h belongs to the A20 sequence
			a20Part = state.gateA20;
		end

		if (wrCmd) begin
			next_state.status[`LKBE_ST_CMD_DATA] = 1'b1;
			if (ioWdata == `LKBE_CMD_GATE_A20) begin
				next_state.gateA20 = 1'b1;
				a20Part            = 1'b1;
			end else begin
				next_state.gateA20 = 1'b0;
			end
		end

		if ((wrData | wrCmd) && !a20Part) begin
			next_state.status[`LKBE_ST_IN_FULL] = 1'b1;
		end

		// Interrupt outputs follow the updated status so they stay in step with it
		next_state.emuIrq =
			(next_state.status[`LKBE_ST_IN_FULL] & emulationEnableBit) |
			(~next_state.status[`LKBE_ST_OUT_FULL] & charPending);
		next_state.kbdIrq = irqDriveEnable &
			next_state.status[`LKBE_ST_OUT_FULL] &
			~next_state.status[`LKBE_ST_AUX_FULL];
		next_state.mouseIrq = irqDriveEnable &
			next_state.status[`LKBE_ST_OUT_FULL] &
			next_state.status[`LKBE_ST_AUX_FULL];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		memRdata              = state.memRdata;
		memAck                = state.memAck;
		ioRdata               = state.ioRdata;
		ioAck                 = state.ioAck;
		ioHit                 = state.ioHit;
		keyboardInterruptLine = state.kbdIrq;
		mouseInterruptLine    = state.mouseIrq;
		emulationInterrupt    = state.emuIrq;
		gateA20SequenceActive = state.gateA20;
	end

endmodule

//--- lkbe_emul_regs_monitor.sv
// Port-level checks of the keyboard emulation registers
`timescale 1ns/10ps
module lkbe_emul_regs_monitor (
	// Clock, reset, control
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        emulationEnableBit,
	input wire logic        irqDriveEnable,
	input wire logic        charPending,
	// Bus cycles
	input wire logic        memReq,
	input wire logic        memAck,
	input wire logic        ioReq,
	input wire logic        ioWrite,
	input wire logic [15:0] ioAddr,
	input wire logic [7:0]  ioWdata,
	input wire logic [7:0]  ioRdata,
	input wire logic        ioAck,
	input wire logic        ioHit,
	// Lines
	input wire logic        keyboardInterruptLine,
	input wire logic        mouseInterruptLine,
	input wire logic        emulationInterrupt,
	input wire logic        gateA20SequenceActive
);
	wire portHit = ioAddr == 16'h0060 || ioAddr == 16'h0064;
	wire enWr64  = ioReq && ioWrite && emulationEnableBit && ioAddr == 16'h0064;
	wire enRd60  = ioReq && !ioWrite && emulationEnableBit && ioAddr == 16'h0060;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_mem_ack; memReq |=> memAck; endproperty
	a_mem_ack: assert property (p_mem_ack) else $error("memory ack missing");
	property p_io_hit; ioReq |=> ioAck && ioHit == $past(emulationEnableBit && portHit); endproperty
	a_io_hit: assert property (p_io_hit) else $error("port claim wrong");
	property p_off; ioReq && !emulationEnableBit |=> !ioHit && ioRdata == 8'h00; endproperty
	a_off: assert property (p_off) else $error("disabled port answered");
	property p_rd60; enRd60 && !memReq |=> !keyboardInterruptLine && !mouseInterruptLine; endproperty
	a_rd60: assert property (p_rd60) else $error("output full not cleared");
	property p_excl; !(keyboardInterruptLine && mouseInterruptLine); endproperty
	a_excl: assert property (p_excl) else $error("both lines driven");
	property p_lines; keyboardInterruptLine || mouseInterruptLine |-> $past(irqDriveEnable); endproperty
	a_lines: assert property (p_lines) else $error("line without enable");
	property p_a20; enWr64 |=> gateA20SequenceActive == ($past(ioWdata) == 8'hD1); endproperty
	a_a20: assert property (p_a20) else $error("sequence state wrong");
	property p_emu; emulationInterrupt |-> $past(emulationEnableBit) || $past(charPending); endproperty
	a_emu: assert property (p_emu) else $error("stray emulation interrupt");
endmodule

bind lkbe_emul_regs lkbe_emul_regs_monitor u_mon (.*);

//--- lkbe_host_model.sv
// Host software side: forms register write words
`timescale 1ns/10ps
module lkbe_host_model (
	// Byte from software
	input  wire logic [7:0]  wrByte,
	// Word on the memory bus
	output logic      [31:0] memWdata
);
	// Reserved bits always written as zero
	assign memWdata = {24'h00_0000, wrByte};
endmodule

//--- testbench.sv
// Self-checking bench of the keyboard emulation registers
`timescale 1ns/10ps
`include "lkbe_params.svh"
module testbench;
	logic        mclk, rst_n, emulationEnableBit, irqDriveEnable, charPending;
	logic        memReq, memWrite, memAck, ioReq, ioWrite, ioAck, ioHit;
	logic        keyboardInterruptLine, mouseInterruptLine;
	logic        emulationInterrupt, gateA20SequenceActive;
	logic [11:0] memAddr;
	logic [31:0] memWdata, memRdata;
	logic [15:0] ioAddr;
	logic [7:0]  ioWdata, ioRdata, wrByte, b;
	logic [32:0] expQ[$];
	logic [32:0] e;
	localparam logic [32:0] SK = 33'h1_0000_0000;
	int          n_mismatch = 0;
	int          num_checks = 0;
	lkbe_emul_regs  u_dut (.*);
	lkbe_host_model u_host (.*);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic mem(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] x);
		@(posedge mclk);
		memReq <= 1'b1;
		memWrite <= w;
		memAddr <= a;
		wrByte <= d;
		expQ.push_back(x);
		@(posedge mclk);
		memReq <= 1'b0;
	endtask
	task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [32:0] x);
		@(posedge mclk);
		ioReq <= 1'b1;
		ioWrite <= w;
		ioAddr <= a;
		ioWdata <= d;
		expQ.push_back(x);
		@(posedge mclk);
		ioReq <= 1'b0;
	endtask
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		if ((memAck === 1'b1 || ioAck === 1'b1) && expQ.size() > 0) begin
			e = expQ.pop_front();
			if (!e[32]) chk(memAck ? memRdata : {23'h0, ioHit, ioRdata}, e[31:0]);
		end
	end
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		complete_run();
	end
	initial begin
		{rst_n, emulationEnableBit, irqDriveEnable, charPending, memReq, memWrite, ioReq} = '0;
		{memAddr, ioAddr, ioWrite, ioWdata, wrByte} = '0;
		void'($urandom(32'h9470CA77));
		b = $urandom;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		emulationEnableBit <= 1'b1;
		irqDriveEnable <= 1'b1;
		mem(0, `LKBE_OFS_INPUT, 0, 0);
		mem(0, `LKBE_OFS_OUTPUT, 0, 0);
		mem(0, `LKBE_OFS_STATUS, 0, 0);
		mem(0, 12'h100, 0, 0);
		mem(1, `LKBE_OFS_OUTPUT, b, SK);
		mem(1, `LKBE_OFS_STATUS, 8'h21, SK);
		#1 chk({keyboardInterruptLine, mouseInterruptLine}, 2'b01);
		io(0, `LKBE_PORT_DATA, 0, {1'b1, b});
		#1 chk({keyboardInterruptLine, mouseInterruptLine}, 2'b00);
		io(0, `LKBE_PORT_CMD, 0, 9'h120);
		io(1, `LKBE_PORT_DATA, ~b, SK);
		#1 chk(emulationInterrupt, 1'b1);
		mem(0, `LKBE_OFS_INPUT, 0, ~b);
		mem(0, `LKBE_OFS_STATUS, 0, 8'h22);
		mem(1, `LKBE_OFS_STATUS, 0, SK);
		io(1, `LKBE_PORT_CMD, 8'hD1, SK);
		#1 chk(gateA20SequenceActive, 1'b1);
		io(1, `LKBE_PORT_DATA, b, SK);
		mem(0, `LKBE_OFS_STATUS, 0, 8'h00);
		io(1, `LKBE_PORT_CMD, 0, SK);
		#1 chk(gateA20SequenceActive, 1'b0);
		mem(0, `LKBE_OFS_STATUS, 0, 8'h0A);
		mem(1, `LKBE_OFS_STATUS, 0, SK);
		charPending <= 1'b1;
		mem(0, `LKBE_OFS_INPUT, 0, 0);
		#1 chk(emulationInterrupt, 1'b1);
		mem(1, `LKBE_OFS_STATUS, 8'hD5, SK);
		#1 chk({keyboardInterruptLine, mouseInterruptLine}, 2'b10);
		mem(0, `LKBE_OFS_STATUS, 0, 8'hD5);
		emulationEnableBit <= 1'b0;
		io(1, `LKBE_PORT_DATA, 8'h5A, SK);
		io(0, `LKBE_PORT_CMD, 0, 0);
		mem(0, `LKBE_OFS_INPUT, 0, 0);
		repeat (3) @(posedge mclk);
		// Every noted expectation must have met an acknowledge
		if (expQ.size() != 0) n_mismatch++;
		complete_run();
	end
endmodule
